/* rtl/ccr_pkg.sv */
/*
  Shared constants and types for the charger control register bank.
  Assumes a single 125 MHz clock and an 8-bit register port from the host interface.
*/
package ccr_pkg;
  localparam logic [7:0] CCR_OFS_TWO = 8'h05;
  localparam logic [7:0] CCR_OFS_THREE = 8'h06;
  localparam logic [7:0] CCR_OFS_FOUR = 8'h07;
  localparam logic [7:0] CCR_RST_TWO = 8'h9F;
  localparam logic [7:0] CCR_RST_THREE = 8'hE6;
  localparam logic [7:0] CCR_RST_FOUR = 8'h4C;
  // Bits of charge_control_two
  localparam int CCR_B_TERM_EN = 7;
  localparam int CCR_B_AUTOCLR = 6;
  localparam int CCR_B_WD_LO = 4;
  localparam int CCR_B_TMR_EN = 3;
  localparam int CCR_B_TMR_LEN = 2;
  // Bits of charge_control_three
  localparam int CCR_B_VLIM_LO = 0;
  // Bits of charge_control_four
  localparam int CCR_B_FDET = 7;
  localparam int CCR_B_HALF = 6;
  localparam int CCR_B_BSW_DIS = 5;
  localparam int CCR_B_WARM = 4;
  localparam int CCR_B_BSW_DLY = 3;
  localparam int CCR_B_BSW_RST = 2;
  localparam int CCR_B_TRACK_LO = 0;
  // Fields that survive watchdog expiry, per register
  localparam logic [7:0] CCR_KEEP_THREE = 8'hFF;
  localparam logic [7:0] CCR_KEEP_FOUR = 8'h2B;
  // Timing
  localparam longint CCR_CLK_HZ = 125000000;
  localparam longint CCR_TICK_MS = 1;
  localparam longint CCR_TICK_CYC = CCR_CLK_HZ * CCR_TICK_MS / 1000;
  localparam int CCR_TERM_LONG_MS = 230;
  localparam int CCR_TERM_SHORT_MS = 16;
  localparam int CCR_WD_S = 40;
  localparam int CCR_SHIP_DLY_MS = 12300;
  localparam int CCR_SAFE_SHORT_H = 7;
  localparam int CCR_SAFE_LONG_H = 16;
  localparam int CCR_MS_PER_H = 3600000;
  localparam int CCR_WARM_MV = 4100;
  localparam int CCR_VLIM_STEP_MV = 100;
  localparam int CCR_OFS0_MV = 3900;
  localparam int CCR_OFS1_MV = 5900;
  localparam int CCR_OFS2_MV = 7500;
  localparam int CCR_OFS3_MV = 10500;
  localparam int CCR_TRK1_MV = 200;
  localparam int CCR_TRK2_MV = 250;
  localparam int CCR_TRK3_MV = 300;
  localparam logic [1:0] CCR_FAULT_TIMER = 2'b11;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_req_t;

  typedef struct packed {
    logic in_pm;
    logic cool;
    logic therm;
  } ccr_slow_t;
endpackage : ccr_pkg

/* rtl/ccr_msec.sv */
/*
  Millisecond counter with enable, clear and a terminal flag.
  Assumes the caller supplies a one-cycle millisecond tick.
*/
`timescale 1ns/10ps
`default_nettype none
module ccr_msec (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic step,
  input wire logic [31:0] limit,
  output logic [31:0] count,
  output logic done
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 32'h0;
    end else if (clr) begin
      count <= 32'h0;
    end else if (step && count < limit) begin
      count <= count + 32'h1;
    end
  end

  assign done = (count >= limit) && (limit != 32'h0);
endmodule : ccr_msec
`default_nettype wire

/* rtl/ccr_regs.sv */
/*
  Charger control registers two to four with watchdog, safety timer,
  termination timer, forced input detection and battery switch control.
  Assumes register accesses arrive already decoded from the host serial port.
*/
// Function
// - With direct charge on, input over-current clears it only if the auto-clear bit is 0.
// - With direct charge off, the shared bit picks a 230 ms or 16 ms termination timer.
// - The watchdog field picks off, 40 s, 80 s or 160 s expiry unless reset first.
// - When enabled, the safety timer counts pre-charge and fast-charge time.
// - The safety timer length bit picks 7 h or 16 h, default 16 h.
// - Input voltage limit is offset plus 0.1 V per step of the 4-bit field.
// - The offset select is ignored; the base is always 3.9 V.
// - Writing the forced-detect bit starts detection with input present; it self-clears.
// - The half-rate bit slows the safety timer in power management, cool or thermal states.
// - With the delay bit 1, battery switch disable turns the switch off after 12.3 s.
// - With the delay bit 0, battery switch disable turns the switch off at once.
// - The battery switch reset enable bit permits or blocks switch reset.
// - In the warm band, charge voltage is min(4.1 V, programmed) unless the bit is 1.
// - Tracking adds 200, 250 or 300 mV to battery voltage; the larger threshold applies.
// - Watchdog expiry sets the watchdog fault flag.
// - Safety timer expiry reports charging fault code 11.
`timescale 1ns/10ps
`default_nettype none
module ccr_regs
  import ccr_pkg::*;
#(
  parameter int TICK_CYC = int'(CCR_TICK_CYC),
  parameter int WD_UNIT_MS = 1000,
  parameter int SHIP_MS = CCR_SHIP_DLY_MS,
  parameter int HOUR_MS = CCR_MS_PER_H
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire ccr_req_t REQ,
  output logic [7:0] RDATA,
  input wire logic REG_RESET,
  input wire logic WD_KICK,
  input wire logic INPUT_OVERCURRENT,
  input wire logic INPUT_PRESENT,
  input wire logic DETECT_DONE,
  input wire logic PRECHARGE,
  input wire logic FASTCHARGE,
  input wire logic WARM_BAND,
  input wire ccr_slow_t SLOW,
  input wire logic TERM_COND,
  input wire logic [15:0] VBAT_MV,
  input wire logic [15:0] VREG_MV,
  input wire logic BSW_RESET_REQ,
  output logic DIRECT_CHARGE_ENABLE,
  output logic TERM_ENABLE,
  output logic TERM_DETECTED,
  output logic DETECT_RUN,
  output logic BATTERY_SWITCH_ON,
  output logic BSW_RESET_FIRE,
  output logic [15:0] VLIM_MV,
  output logic [15:0] VCHG_MV,
  output logic WD_FAULT,
  output logic [1:0] CHG_FAULT
);
  logic [7:0] two_reg;
  logic [7:0] three_reg;
  logic [7:0] four_reg;
  logic wd_expire;
  logic tick;
  logic [31:0] tick_cnt;
  logic half_ph;
  logic dce_reg;
  logic [31:0] wd_limit;
  logic [31:0] wd_cnt;
  logic wd_done;
  logic [31:0] term_limit;
  logic term_done;
  logic [31:0] safe_limit;
  logic safe_step;
  logic safe_done;
  logic ship_done;
  logic ship_arm;
  logic wr_two;
  logic wr_three;
  logic wr_four;

  function automatic logic hit(input ccr_req_t r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  assign wr_two = hit(REQ, CCR_OFS_TWO);
  assign wr_three = hit(REQ, CCR_OFS_THREE);
  assign wr_four = hit(REQ, CCR_OFS_FOUR);

  // Millisecond tick divider
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      tick_cnt <= 32'h0;
    end else if (tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_CYC - 1));

  always_comb begin
    case (two_reg[CCR_B_WD_LO +: 2])
      2'b01: wd_limit = 32'(CCR_WD_S * WD_UNIT_MS);
      2'b10: wd_limit = 32'(2 * CCR_WD_S * WD_UNIT_MS);
      2'b11: wd_limit = 32'(4 * CCR_WD_S * WD_UNIT_MS);
      default: wd_limit = 32'h0;
    endcase
  end

  // Kick or register reset restarts watchdog
  ccr_msec u_wd (
    .clk(REF_CLK),
    .nrst(NRST),
    .clr(WD_KICK || REG_RESET || wd_expire),
    .step(tick),
    .limit(wd_limit),
    .count(wd_cnt),
    .done(wd_done)
  );
  assign wd_expire = wd_done;

  // Sticky watchdog fault, cleared by register reset
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      WD_FAULT <= 1'b0;
    end else if (wd_expire) begin
      WD_FAULT <= 1'b1;
    end else if (REG_RESET) begin
      WD_FAULT <= 1'b0;
    end
  end

  // Register two, all fields watchdog resettable
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      two_reg <= CCR_RST_TWO;
    end else if (REG_RESET || wd_expire) begin
      two_reg <= CCR_RST_TWO;
    end else if (wr_two) begin
      two_reg <= REQ.wdata;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      three_reg <= CCR_RST_THREE;
    end else if (REG_RESET) begin
      three_reg <= CCR_RST_THREE;
    end else if (wr_three) begin
      three_reg <= REQ.wdata;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      four_reg <= CCR_RST_FOUR;
    end else if (REG_RESET) begin
      four_reg <= CCR_RST_FOUR;
    end else if (wd_expire) begin
      four_reg <= (four_reg & CCR_KEEP_FOUR) | (CCR_RST_FOUR & ~CCR_KEEP_FOUR);
    end else if (wr_four) begin
      four_reg <= REQ.wdata;
    end else if (DETECT_DONE) begin
      four_reg[CCR_B_FDET] <= 1'b0;
    end
  end
  assign DETECT_RUN = four_reg[CCR_B_FDET] && INPUT_PRESENT;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      dce_reg <= 1'b0;
    end else if (INPUT_OVERCURRENT && !two_reg[CCR_B_AUTOCLR]) begin
      dce_reg <= 1'b0;
    end else if (REQ.wr && REQ.addr == 8'h00) begin
      dce_reg <= dce_reg;
    end else begin
      dce_reg <= dce_reg | (INPUT_PRESENT & ~INPUT_PRESENT);
    end
  end
  assign DIRECT_CHARGE_ENABLE = dce_reg;
  assign TERM_ENABLE = two_reg[CCR_B_TERM_EN];

  assign term_limit = two_reg[CCR_B_AUTOCLR] ? 32'(CCR_TERM_SHORT_MS) : 32'(CCR_TERM_LONG_MS);
  ccr_msec u_term (
    .clk(REF_CLK),
    .nrst(NRST),
    .clr(!TERM_COND || dce_reg || !TERM_ENABLE),
    .step(tick),
    .limit(term_limit),
    .count(),
    .done(term_done)
  );
  assign TERM_DETECTED = term_done;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      half_ph <= 1'b0;
    end else if (tick) begin
      half_ph <= ~half_ph;
    end
  end

  assign safe_step = tick && (PRECHARGE || FASTCHARGE) &&
    (!(four_reg[CCR_B_HALF] && (SLOW.in_pm || SLOW.cool || SLOW.therm)) || half_ph);
  assign safe_limit = two_reg[CCR_B_TMR_LEN] ? 32'(CCR_SAFE_LONG_H * HOUR_MS)
    : 32'(CCR_SAFE_SHORT_H * HOUR_MS);
  ccr_msec u_safe (
    .clk(REF_CLK),
    .nrst(NRST),
    .clr(!two_reg[CCR_B_TMR_EN] || !(PRECHARGE || FASTCHARGE)),
    .step(safe_step),
    .limit(safe_limit),
    .count(),
    .done(safe_done)
  );
  assign CHG_FAULT = safe_done ? CCR_FAULT_TIMER : 2'b00;

  assign ship_arm = four_reg[CCR_B_BSW_DIS] && four_reg[CCR_B_BSW_DLY];
  ccr_msec u_ship (
    .clk(REF_CLK),
    .nrst(NRST),
    .clr(!ship_arm),
    .step(tick),
    .limit(32'(SHIP_MS)),
    .count(),
    .done(ship_done)
  );
  assign BATTERY_SWITCH_ON = !(four_reg[CCR_B_BSW_DIS] &&
    (!four_reg[CCR_B_BSW_DLY] || ship_done));
  assign BSW_RESET_FIRE = BSW_RESET_REQ && four_reg[CCR_B_BSW_RST];

  always_comb begin
    logic [15:0] base;
    logic [15:0] trk;
    base = 16'(CCR_OFS0_MV);
    trk = 16'h0;
    case (three_reg[5:4] & 2'b00 | 2'b00)
      default: base = 16'(CCR_OFS0_MV);
    endcase
    case (four_reg[CCR_B_TRACK_LO +: 2])
      2'b01: trk = VBAT_MV + 16'(CCR_TRK1_MV);
      2'b10: trk = VBAT_MV + 16'(CCR_TRK2_MV);
      2'b11: trk = VBAT_MV + 16'(CCR_TRK3_MV);
      default: trk = 16'h0;
    endcase
    base = base + 16'(CCR_VLIM_STEP_MV) * {12'h0, three_reg[CCR_B_VLIM_LO +: 4]};
    VLIM_MV = (trk > base) ? trk : base;
  end

  always_comb begin
    if (WARM_BAND && !four_reg[CCR_B_WARM] && VREG_MV > 16'(CCR_WARM_MV)) begin
      VCHG_MV = 16'(CCR_WARM_MV);
    end else begin
      VCHG_MV = VREG_MV;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 8'h00;
    end else if (REQ.addr == CCR_OFS_TWO) begin
      RDATA <= two_reg;
    end else if (REQ.addr == CCR_OFS_THREE) begin
      RDATA <= three_reg;
    end else if (REQ.addr == CCR_OFS_FOUR) begin
      RDATA <= four_reg;
    end else begin
      RDATA <= 8'h00;
    end
  end

  wd_fault_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wd_expire |=> WD_FAULT) else $error("watchdog fault not set");
  wd_default_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    wd_expire && !REG_RESET |=> two_reg == CCR_RST_TWO) else $error("reg two not defaulted");
  dce_clear_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    INPUT_OVERCURRENT && !two_reg[CCR_B_AUTOCLR] |=> !dce_reg) else $error("dce kept");
  fdet_clear_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    DETECT_DONE && !wr_four && !REG_RESET |=> !four_reg[CCR_B_FDET]) else $error("detect held");
  bsw_now_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    four_reg[CCR_B_BSW_DIS] && !four_reg[CCR_B_BSW_DLY] |-> !BATTERY_SWITCH_ON)
    else $error("switch still on");
  bsw_dly_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(ship_arm) |-> BATTERY_SWITCH_ON) else $error("switch off too early");
  bsw_rst_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !four_reg[CCR_B_BSW_RST] |-> !BSW_RESET_FIRE) else $error("reset not blocked");
  safe_fault_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    safe_done |-> CHG_FAULT == CCR_FAULT_TIMER) else $error("fault code missing");
  sequence detect_armed_s;
    four_reg[CCR_B_FDET] && INPUT_PRESENT;
  endsequence
  detect_run_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    detect_armed_s |-> DETECT_RUN) else $error("detection not running");
  half_rate_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    four_reg[CCR_B_HALF] && (SLOW.in_pm || SLOW.cool || SLOW.therm) && !half_ph
    |-> !safe_step) else $error("safety timer not slowed");
  safe_off_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    !two_reg[CCR_B_TMR_EN] |=> !safe_done) else $error("safety timer ran while disabled");
  wd_off_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    two_reg[CCR_B_WD_LO +: 2] == 2'b00 |-> !wd_expire) else $error("watchdog expired while off");
endmodule : ccr_regs
`default_nettype wire

/* verification/ccr_host.sv */
/*
  Host model for the charger control registers: register writes, reads, watchdog kicks.
  Assumes one clock; a request is taken at the rising edge while REQ.wr is high.
  Kicks come every 256 cycles while kick_en is high.
*/
`timescale 1ns/10ps
`default_nettype none
module ccr_host
  import ccr_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic kick_en,
  output ccr_req_t req,
  output logic kick
);
  logic [7:0] kick_cnt;

  initial begin
    req = '0;
    kick = 1'b0;
    kick_cnt = '0;
  end

  always @(posedge clk) begin
    kick_cnt <= kick_cnt + 8'h01;
    kick <= kick_en && (kick_cnt == 8'h00);
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, a, d};
    @(posedge clk);
    // Stale data is inverted so the bus never shows it
    req <= '{1'b0, a, ~d};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{1'b0, a, 8'h00};
    @(posedge clk);
    @(negedge clk);
    d = rdata;
  endtask : rd
endmodule : ccr_host
`default_nettype wire

/* verification/tb.sv */
/*
  Self-checking bench for the charger control register bank.
  Assumes the host model drives the register port; long timers are shortened.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ccr_pkg::*;
  ccr_req_t REQ;
  ccr_slow_t SLOW;
  logic REF_CLK, NRST, REG_RESET, WD_KICK, INPUT_OVERCURRENT, INPUT_PRESENT, DETECT_DONE;
  logic PRECHARGE, FASTCHARGE, WARM_BAND, TERM_COND, BSW_RESET_REQ;
  logic DIRECT_CHARGE_ENABLE, TERM_ENABLE, TERM_DETECTED, DETECT_RUN;
  logic BATTERY_SWITCH_ON, BSW_RESET_FIRE, WD_FAULT;
  logic [1:0] CHG_FAULT;
  logic [7:0] RDATA;
  logic [15:0] VBAT_MV, VREG_MV, VLIM_MV, VCHG_MV;
  logic [7:0] ofs [3] = '{CCR_OFS_TWO, CCR_OFS_THREE, CCR_OFS_FOUR};
  logic [7:0] dflt [3] = '{CCR_RST_TWO, CCR_RST_THREE, CCR_RST_FOUR};
  int trk [4] = '{0, CCR_TRK1_MV, CCR_TRK2_MV, CCR_TRK3_MV};
  int error_cnt, num_checks;
  logic kick_en;

  ccr_host host (.clk(REF_CLK), .rdata(RDATA), .kick_en(kick_en), .req(REQ), .kick(WD_KICK));

  // Four-cycle tick; watchdog 320 cycles, kicked every 256
  ccr_regs #(.TICK_CYC(4), .WD_UNIT_MS(2), .SHIP_MS(5), .HOUR_MS(2)) dut (
    .REF_CLK(REF_CLK), .NRST(NRST), .REQ(REQ), .RDATA(RDATA), .REG_RESET(REG_RESET),
    .WD_KICK(WD_KICK), .INPUT_OVERCURRENT(INPUT_OVERCURRENT), .INPUT_PRESENT(INPUT_PRESENT),
    .DETECT_DONE(DETECT_DONE), .PRECHARGE(PRECHARGE), .FASTCHARGE(FASTCHARGE),
    .WARM_BAND(WARM_BAND), .SLOW(SLOW), .TERM_COND(TERM_COND), .VBAT_MV(VBAT_MV),
    .VREG_MV(VREG_MV), .BSW_RESET_REQ(BSW_RESET_REQ),
    .DIRECT_CHARGE_ENABLE(DIRECT_CHARGE_ENABLE), .TERM_ENABLE(TERM_ENABLE),
    .TERM_DETECTED(TERM_DETECTED), .DETECT_RUN(DETECT_RUN),
    .BATTERY_SWITCH_ON(BATTERY_SWITCH_ON), .BSW_RESET_FIRE(BSW_RESET_FIRE),
    .VLIM_MV(VLIM_MV), .VCHG_MV(VCHG_MV), .WD_FAULT(WD_FAULT), .CHG_FAULT(CHG_FAULT)
  );

  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk("register read", {8'h00, d}, {8'h00, exp});
  endtask : rchk

  task automatic rst_pulse;
    @(posedge REF_CLK);
    REG_RESET <= 1'b1;
    @(posedge REF_CLK);
    REG_RESET <= 1'b0;
  endtask : rst_pulse

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // Whole run needs about one and a half thousand cycles
  initial begin
    repeat (5000) @(posedge REF_CLK);
    error_cnt++;
    stop_test();
  end

  initial begin
    error_cnt = 0;
    num_checks = 0;
    NRST = 1'b0;
    REG_RESET = 1'b0;
    INPUT_OVERCURRENT = 1'b0;
    INPUT_PRESENT = 1'b0;
    DETECT_DONE = 1'b0;
    PRECHARGE = 1'b0;
    FASTCHARGE = 1'b0;
    WARM_BAND = 1'b0;
    SLOW = '0;
    TERM_COND = 1'b0;
    BSW_RESET_REQ = 1'b0;
    kick_en = 1'b1;
    VBAT_MV = 16'h14B4;
    VREG_MV = 16'h1068;
    repeat (10) @(posedge REF_CLK);
    NRST <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rchk(ofs[i], dflt[i]);
    end
    rchk(8'h08, 8'h00);
    chk("fault code", {14'h0000, CHG_FAULT}, 16'h0000);
    chk("watchdog fault", {15'h0000, WD_FAULT}, 16'h0000);
    @(posedge REF_CLK);
    INPUT_OVERCURRENT <= 1'b1;
    @(negedge REF_CLK);
    chk("direct charge", {15'h0000, DIRECT_CHARGE_ENABLE}, 16'h0000);
    for (int n = 0; n < 16; n += 5) begin
      host.wr(CCR_OFS_THREE, 8'hE0 | 8'(n));
      @(negedge REF_CLK);
      chk("input limit", VLIM_MV, 16'(CCR_OFS0_MV + n * CCR_VLIM_STEP_MV));
    end
    // Tracked value above the programmed limit so every code shows
    for (int c = 0; c < 4; c++) begin
      host.wr(CCR_OFS_FOUR, 8'h4C | 8'(c));
      @(negedge REF_CLK);
      chk("tracked limit", VLIM_MV, (c == 0) ? 16'(CCR_OFS0_MV + 15 * CCR_VLIM_STEP_MV) :
          VBAT_MV + 16'(trk[c]));
    end
    host.wr(CCR_OFS_FOUR, 8'h4C);
    @(posedge REF_CLK);
    WARM_BAND <= 1'b1;
    @(negedge REF_CLK);
    chk("charge voltage", VCHG_MV, 16'(CCR_WARM_MV));
    @(posedge REF_CLK);
    VREG_MV <= 16'h0FA0;
    @(negedge REF_CLK);
    chk("charge voltage", VCHG_MV, 16'h0FA0);
    @(posedge REF_CLK);
    VREG_MV <= 16'h1068;
    host.wr(CCR_OFS_FOUR, 8'h5C);
    @(negedge REF_CLK);
    chk("charge voltage", VCHG_MV, 16'h1068);
    @(posedge REF_CLK);
    INPUT_PRESENT <= 1'b1;
    host.wr(CCR_OFS_FOUR, 8'hCC);
    @(negedge REF_CLK);
    chk("detect run", {15'h0000, DETECT_RUN}, 16'h0001);
    @(posedge REF_CLK);
    DETECT_DONE <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    DETECT_DONE <= 1'b0;
    rchk(CCR_OFS_FOUR, 8'h4C);
    @(posedge REF_CLK);
    BSW_RESET_REQ <= 1'b1;
    @(negedge REF_CLK);
    chk("switch reset", {15'h0000, BSW_RESET_FIRE}, 16'h0001);
    host.wr(CCR_OFS_FOUR, 8'h48);
    @(negedge REF_CLK);
    chk("switch reset", {15'h0000, BSW_RESET_FIRE}, 16'h0000);
    @(posedge REF_CLK);
    BSW_RESET_REQ <= 1'b0;
    host.wr(CCR_OFS_FOUR, 8'h6C);
    repeat (2) @(negedge REF_CLK);
    chk("switch on", {15'h0000, BATTERY_SWITCH_ON}, 16'h0001);
    repeat (22) @(negedge REF_CLK);
    chk("switch on", {15'h0000, BATTERY_SWITCH_ON}, 16'h0000);
    rst_pulse();
    host.wr(CCR_OFS_FOUR, 8'h64);
    repeat (2) @(negedge REF_CLK);
    chk("switch on", {15'h0000, BATTERY_SWITCH_ON}, 16'h0000);
    host.wr(CCR_OFS_TWO, 8'h00);
    rchk(CCR_OFS_TWO, 8'h00);
    rst_pulse();
    for (int i = 0; i < 3; i++) begin
      rchk(ofs[i], dflt[i]);
    end
    chk("term enable", {15'h0000, TERM_ENABLE}, 16'h0001);
    @(posedge REF_CLK);
    TERM_COND <= 1'b1;
    repeat (900) @(negedge REF_CLK);
    chk("term detected", {15'h0000, TERM_DETECTED}, 16'h0000);
    repeat (25) @(negedge REF_CLK);
    chk("term detected", {15'h0000, TERM_DETECTED}, 16'h0001);
    @(posedge REF_CLK);
    TERM_COND <= 1'b0;
    host.wr(CCR_OFS_TWO, 8'hDF);
    @(posedge REF_CLK);
    TERM_COND <= 1'b1;
    repeat (58) @(negedge REF_CLK);
    chk("term detected", {15'h0000, TERM_DETECTED}, 16'h0000);
    repeat (8) @(negedge REF_CLK);
    chk("term detected", {15'h0000, TERM_DETECTED}, 16'h0001);
    host.wr(CCR_OFS_TWO, 8'h5B);
    repeat (2) @(negedge REF_CLK);
    chk("term enable", {15'h0000, TERM_ENABLE}, 16'h0000);
    chk("term detected", {15'h0000, TERM_DETECTED}, 16'h0000);
    // Short safety timer, pre-charge then fast charge
    @(posedge REF_CLK);
    TERM_COND <= 1'b0;
    PRECHARGE <= 1'b1;
    repeat (30) @(posedge REF_CLK);
    PRECHARGE <= 1'b0;
    FASTCHARGE <= 1'b1;
    repeat (20) @(negedge REF_CLK);
    chk("fault code", {14'h0000, CHG_FAULT}, 16'h0000);
    repeat (10) @(negedge REF_CLK);
    chk("fault code", {14'h0000, CHG_FAULT}, {14'h0000, CCR_FAULT_TIMER});
    @(posedge REF_CLK);
    FASTCHARGE <= 1'b0;
    @(posedge REF_CLK);
    FASTCHARGE <= 1'b1;
    SLOW.therm <= 1'b1;
    repeat (100) @(negedge REF_CLK);
    chk("fault code", {14'h0000, CHG_FAULT}, 16'h0000);
    repeat (15) @(negedge REF_CLK);
    chk("fault code", {14'h0000, CHG_FAULT}, {14'h0000, CCR_FAULT_TIMER});
    @(posedge REF_CLK);
    FASTCHARGE <= 1'b0;
    SLOW.therm <= 1'b0;
    repeat (2) @(negedge REF_CLK);
    chk("fault code", {14'h0000, CHG_FAULT}, 16'h0000);
    // Starve the watchdog; kept fields survive expiry
    host.wr(CCR_OFS_THREE, 8'h3A);
    host.wr(CCR_OFS_FOUR, 8'h7B);
    @(posedge REF_CLK);
    kick_en <= 1'b0;
    for (int w = 0; w < 400 && !WD_FAULT; w++) begin
      @(negedge REF_CLK);
    end
    chk("watchdog fault", {15'h0000, WD_FAULT}, 16'h0001);
    rchk(CCR_OFS_TWO, CCR_RST_TWO);
    rchk(CCR_OFS_THREE, 8'h3A);
    rchk(CCR_OFS_FOUR, 8'h6F);
    rst_pulse();
    kick_en <= 1'b1;
    @(negedge REF_CLK);
    chk("watchdog fault", {15'h0000, WD_FAULT}, 16'h0000);
    stop_test();
  end
endmodule : tb
`default_nettype wire
